// ==== design/pfs_pkg.sv ====
// Package for the four-pin strobe decoder port: register map, fields, mode codes.
// Assumes an AHB-Lite register bus with 32-bit data and one aligned word per register.
package pfs_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    // Port data register, and the block's own configuration words.
    localparam logic [7:0] PFS_OFS_DATA = 8'he8;
    localparam logic [7:0] PFS_OFS_MODE_A = 8'h00;
    localparam logic [7:0] PFS_OFS_MODE_B = 8'h04;
    localparam logic [7:0] PFS_OFS_INV = 8'h08;
    localparam logic [7:0] PFS_OFS_IRQ_EN = 8'h0c;
    localparam logic [7:0] PFS_OFS_PIN_STATE = 8'h10;
    localparam logic [7:0] PFS_OFS_CMP_BASE = 8'h20;
    localparam logic [7:0] PFS_OFS_CMP_STEP = 8'h04;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int PFS_PINS = 4;
    localparam int PFS_MODE_LSB = 2;
    localparam int PFS_MASK_LSB = 0;
    localparam logic [3:0] PFS_DATA_RST = 4'hf;
    localparam logic [7:0] PFS_MODE_RST = 8'h00;
    localparam logic [15:0] PFS_CMP_RST = 16'h0000;
    localparam logic [1:0] PFS_IRQ_B_PIN = 2'd3;
    localparam logic [1:0] PFS_IRQ_C_PIN = 2'd2;

    typedef enum logic [1:0] {
        PFS_MODE_GPIO = 2'd0,
        PFS_MODE_RD = 2'd1,
        PFS_MODE_WR = 2'd2,
        PFS_MODE_RW = 2'd3
    } pfs_mode_t;

    // External data access of the core.
    typedef struct packed {
        logic [15:0] addr;
        logic rd_n;
        logic wr_n;
    } pfs_xacc_t;

    // Pin drive group.
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } pfs_pins_t;

endpackage : pfs_pkg

// ==== design/pfs_port.sv ====
// Four-pin multi-purpose port: quasi-bidirectional I/O or address-decoded strobes.
// Assumes the core's external access signals arrive on i_mclk; pin levels are asynchronous.
//
// Contract
// [R1] Four pins, each configured independently of the others.
// [R2] Four modes per pin, chosen by two mode-control registers.
// [R3] Mode 0: bidirectional pin with pull-up showing the data register bit.
// [R4] Mode 0: pin 2 feeds irq c, pin 3 feeds irq b, when enabled.
// [R5] Mode 1: strobe follows external read strobe at matching addresses.
// [R6] Mode 2: strobe follows external write strobe at matching addresses.
// [R7] Mode 3: strobe follows read or write strobe at matching addresses.
// [R8] Each pin has its own 16-bit comparator from high and low bytes.
// [R9] Mode control can mask the lowest address lines from the compare.
// [R10] Per-pin invert bit turns the strobe to positive polarity.
// [R11] Strobe inactive with no access or with an address mismatch.
// [R12] Strobe pins drive the strobe; mode-0 pins keep port data behaviour.
`timescale 1ns/1ps

module pfs_port (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire pfs_pkg::pfs_xacc_t i_xacc,
    input wire logic [3:0] i_pin,
    output logic [3:0] o_pin,
    output logic [3:0] o_pin_oe,
    output logic o_external_irq_b_n,
    output logic o_external_irq_c_n
);
    import pfs_pkg::*;

    // ************************************************************
    // Register state
    // ************************************************************
    logic [3:0] port_four_data, next_port_four_data;
    logic [7:0] pin_mode_control_a, next_pin_mode_control_a;
    logic [7:0] pin_mode_control_b, next_pin_mode_control_b;
    logic [3:0] strobe_polarity_invert, next_strobe_polarity_invert;
    logic [1:0] irq_en, next_irq_en;
    logic [15:0] strobe_compare [PFS_PINS];
    logic [15:0] next_strobe_compare [PFS_PINS];
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_ofs, next_wr_ofs;
    logic [31:0] rdata, next_rdata;
    logic [3:0] pin_s1, pin_s2;
    logic [1:0] mask_sel [PFS_PINS];
    wire logic [3:0] strobe_act;
    pfs_pins_t next_pins, pins;
    logic next_irq_b_n, next_irq_c_n;
    logic irq_b_n, irq_c_n;
    logic bus_ready;
    logic bus_err;
    logic [7:0] aofs;
    logic take;

    // ************************************************************
    // Pin input synchroniser
    // ************************************************************
    // Two flops keep a metastable pin level away from the irq and readback logic.
    // Only the second flop is read anywhere else in the block.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1 <= 4'hf;
            pin_s2 <= 4'hf;
        end else begin
            pin_s1 <= i_pin;
            pin_s2 <= pin_s1;
        end
    end

    // ************************************************************
    // Per-pin mode fields
    // ************************************************************
    // Pins 0 and 1 live in control a, pins 2 and 3 in control b; each nibble holds mode and mask.
    // The mask field counts address lines: one drops A0, two or three drop A0 and A1.
    // A mask of zero compares all sixteen address lines.
    pfs_mode_t pin_mode [PFS_PINS];
    always_comb begin
        for (int p = 0; p < PFS_PINS; p++) begin
            logic [3:0] nib;
            nib = (p < 2) ? pin_mode_control_a[4*(p%2) +: 4] : pin_mode_control_b[4*(p%2) +: 4]; // see [R2]
            pin_mode[p] = pfs_mode_t'(nib[PFS_MODE_LSB +: 2]); // see [R1]
            mask_sel[p] = nib[PFS_MASK_LSB +: 2];
        end
    end

    // ************************************************************
    // Strobe decoding
    // ************************************************************
    for (genvar p = 0; p < PFS_PINS; p++) begin : g_strobe
        pfs_strobe_unit u_pfs_strobe_unit (
            .i_addr(i_xacc.addr),
            .i_rd_n(i_xacc.rd_n),
            .i_wr_n(i_xacc.wr_n),
            .i_cmp(strobe_compare[p]),
            .i_mode(pin_mode[p]),
            .i_mask(mask_sel[p]),
            .o_act(strobe_act[p])
        );
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    // Mode-0 pins drive only a low; a high is left to the pull-up, as on a quasi-bidirectional port.
    always_comb begin
        for (int p = 0; p < PFS_PINS; p++) begin
            if (pin_mode[p] == PFS_MODE_GPIO) begin
                next_pins.out[p] = 1'b0; // see [R3] [R12]
                next_pins.oe[p] = ~port_four_data[p]; // see [R3]
            end else begin
                // Default strobe is active low; the invert bit makes it active high.
                next_pins.out[p] = ~strobe_act[p] ^ strobe_polarity_invert[p]; // see [R10] [R12]
                next_pins.oe[p] = 1'b1; // see [R12]
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pins <= '0;
        end else begin
            pins <= next_pins;
        end
    end

    // ************************************************************
    // External interrupt lines
    // ************************************************************
    // A pin in a strobe mode never raises an interrupt, even when it is enabled.
    always_comb begin
        next_irq_b_n = ~(irq_en[0] && pin_mode[PFS_IRQ_B_PIN] == PFS_MODE_GPIO && !pin_s2[PFS_IRQ_B_PIN]); // see [R4]
        next_irq_c_n = ~(irq_en[1] && pin_mode[PFS_IRQ_C_PIN] == PFS_MODE_GPIO && !pin_s2[PFS_IRQ_C_PIN]); // see [R4]
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_b_n <= 1'b1;
            irq_c_n <= 1'b1;
        end else begin
            irq_b_n <= next_irq_b_n;
            irq_c_n <= next_irq_c_n;
        end
    end

    assign o_pin = pins.out;
    assign o_pin_oe = pins.oe;
    assign o_external_irq_b_n = irq_b_n;
    assign o_external_irq_c_n = irq_c_n;

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    // Zero wait states: write data lands at the data-phase edge, read data is registered at the address phase.
    // A write is remembered for one cycle, because its data follow its address by one cycle.
    // Read data are loaded at the address phase, so hrdata stands through the whole data phase.
    // Unmapped offsets read as zero and ignore writes.
    // The transfer size is not checked: every access is taken as a whole word.
    assign aofs = i_haddr[7:0];
    assign take = i_hsel & i_hready & i_htrans[1];

    always_comb begin
        next_port_four_data = port_four_data;
        next_pin_mode_control_a = pin_mode_control_a;
        next_pin_mode_control_b = pin_mode_control_b;
        next_strobe_polarity_invert = strobe_polarity_invert;
        next_irq_en = irq_en;
        next_strobe_compare = strobe_compare;
        next_wr_pend = take & i_hwrite;
        next_wr_ofs = take ? aofs : wr_ofs;
        next_rdata = rdata;
        if (wr_pend) begin
            case (wr_ofs)
                PFS_OFS_DATA: next_port_four_data = i_hwdata[3:0];
                PFS_OFS_MODE_A: next_pin_mode_control_a = i_hwdata[7:0];
                PFS_OFS_MODE_B: next_pin_mode_control_b = i_hwdata[7:0];
                PFS_OFS_INV: next_strobe_polarity_invert = i_hwdata[3:0];
                PFS_OFS_IRQ_EN: next_irq_en = i_hwdata[1:0];
                default: begin
                    for (int p = 0; p < PFS_PINS; p++) begin
                        if (wr_ofs == PFS_OFS_CMP_BASE + 8'(p) * PFS_OFS_CMP_STEP) begin
                            next_strobe_compare[p] = i_hwdata[15:0];
                        end
                    end
                end
            endcase
        end
        if (take && !i_hwrite) begin
            next_rdata = 32'h0000_0000;
            case (aofs)
                PFS_OFS_DATA: next_rdata[3:0] = port_four_data;
                PFS_OFS_MODE_A: next_rdata[7:0] = pin_mode_control_a;
                PFS_OFS_MODE_B: next_rdata[7:0] = pin_mode_control_b;
                PFS_OFS_INV: next_rdata[3:0] = strobe_polarity_invert;
                PFS_OFS_IRQ_EN: next_rdata[1:0] = irq_en;
                PFS_OFS_PIN_STATE: next_rdata[3:0] = pin_s2;
                default: begin
                    for (int p = 0; p < PFS_PINS; p++) begin
                        if (aofs == PFS_OFS_CMP_BASE + 8'(p) * PFS_OFS_CMP_STEP) begin
                            next_rdata[15:0] = strobe_compare[p];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            port_four_data <= PFS_DATA_RST;
            pin_mode_control_a <= PFS_MODE_RST;
            pin_mode_control_b <= PFS_MODE_RST;
            strobe_polarity_invert <= 4'h0;
            irq_en <= 2'b00;
            for (int p = 0; p < PFS_PINS; p++) begin
                strobe_compare[p] <= PFS_CMP_RST;
            end
            wr_pend <= 1'b0;
            wr_ofs <= 8'h00;
            rdata <= 32'h0000_0000;
        end else begin
            port_four_data <= next_port_four_data;
            pin_mode_control_a <= next_pin_mode_control_a;
            pin_mode_control_b <= next_pin_mode_control_b;
            strobe_polarity_invert <= next_strobe_polarity_invert;
            irq_en <= next_irq_en;
            strobe_compare <= next_strobe_compare;
            wr_pend <= next_wr_pend;
            wr_ofs <= next_wr_ofs;
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Bus response
    // ************************************************************
    // Every transfer ends with no wait state and an OKAY answer; both are held in flops.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            bus_ready <= 1'b1;
            bus_err <= 1'b0;
        end else begin
            bus_ready <= 1'b1;
            bus_err <= 1'b0;
        end
    end

    assign o_hrdata = rdata;
    assign o_hreadyout = bus_ready;
    assign o_hresp = bus_err;

endmodule : pfs_port

// ************************************************************
// Per-pin address comparator and strobe gate
// ************************************************************
// One instance per pin, so that every pin has its own comparator, mode and mask.
module pfs_strobe_unit (
    input wire logic [15:0] i_addr,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [15:0] i_cmp,
    input wire pfs_pkg::pfs_mode_t i_mode,
    input wire logic [1:0] i_mask,
    output logic o_act
);
    import pfs_pkg::*;

    logic [15:0] amask;
    logic hit;

    // A mask of one drops A0; two or more drop A0 and A1, so a strobe covers four addresses.
    always_comb begin
        amask = 16'hffff;
        amask[0] = (i_mask == 2'd0); // see [R9]
        amask[1] = (i_mask < 2'd2); // see [R9]
    end

    assign hit = ((i_addr ^ i_cmp) & amask) == 16'h0000; // see [R8]

    // With no access in progress, or on a mismatch, the strobe stays inactive.
    always_comb begin
        case (i_mode)
            PFS_MODE_RD: o_act = hit & ~i_rd_n; // see [R5] [R11]
            PFS_MODE_WR: o_act = hit & ~i_wr_n; // see [R6] [R11]
            PFS_MODE_RW: o_act = hit & (~i_rd_n | ~i_wr_n); // see [R7] [R11]
            default: o_act = 1'b0;
        endcase
    end

endmodule : pfs_strobe_unit

// ==== tb/pfs_monitor.sv ====
// Checker for pfs_port: bus answers, pin drive and irq follow-up.
// Assumes it is bound to every pfs_port instance.
`timescale 1ns/1ps
module pfs_monitor (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire pfs_pkg::pfs_xacc_t i_xacc,
    input wire logic [3:0] i_pin,
    input wire logic [3:0] o_pin,
    input wire logic [3:0] o_pin_oe,
    input wire logic o_external_irq_b_n,
    input wire logic o_external_irq_c_n
);
    import pfs_pkg::*;
    logic take;
    logic wr_data;
    logic [3:0] shadow;
    assign take = i_hsel & i_hready & i_htrans[1];
    // Shadow of the data register, so a read can be tied to the last write.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_data <= 1'b0;
            shadow <= PFS_DATA_RST;
        end else begin
            wr_data <= take & i_hwrite & (i_haddr[7:0] == PFS_OFS_DATA);
            if (wr_data) begin
                shadow <= i_hwdata[3:0];
            end
        end
    end
    default clocking mon_cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus not ready or not okay");
    a_released_low: assert property ((o_pin & ~o_pin_oe) == 4'h0) else $error("undriven pin");
    a_pin_hold: assert property ($stable(i_xacc) && !take && !$past(take) && !$past(take, 2)
        |=> $stable(o_pin)) else $error("pin moved without cause");
    a_irq_b_cause: assert property (!o_external_irq_b_n |-> !$past(i_pin[3]) || !$past(i_pin[3], 2)
        || !$past(i_pin[3], 3) || !$past(i_pin[3], 4)) else $error("irq b without low pin");
    a_irq_c_cause: assert property (!o_external_irq_c_n |-> !$past(i_pin[2]) || !$past(i_pin[2], 2)
        || !$past(i_pin[2], 3) || !$past(i_pin[2], 4)) else $error("irq c without low pin");
    a_rdata_hold: assert property (!$past(take && !i_hwrite) |-> $stable(o_hrdata))
        else $error("read data moved");
    a_rdata_upper: assert property (take && !i_hwrite |=> o_hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_data_back: assert property (take && !i_hwrite && i_haddr[7:0] == PFS_OFS_DATA
        |=> o_hrdata[3:0] == shadow) else $error("data readback wrong");
endmodule : pfs_monitor
bind pfs_port pfs_monitor u_pfs_monitor (.i_mclk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
    .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_xacc, .i_pin, .o_pin, .o_pin_oe, .o_external_irq_b_n,
    .o_external_irq_c_n);

// ==== tb/pfs_periph.sv ====
// Pin side model: pull-ups, plus a device that may sink a released pin.
// Assumes drive and enable come straight from pfs_port.
`timescale 1ns/1ps
module pfs_periph (
    input wire logic [3:0] i_drive,
    input wire logic [3:0] i_drive_oe,
    input wire logic [3:0] i_pull_low,
    output logic [3:0] o_level
);
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            o_level[p] = i_drive_oe[p] ? i_drive[p] : !i_pull_low[p];
        end
    end
endmodule : pfs_periph

// ==== tb/tb_top.sv ====
// Testbench for pfs_port: registers over AHB-Lite, mode-0 pins, irq and strobes.
// Assumes pfs_periph resolves the pins.
`timescale 1ns/1ps
module tb_top;
    import pfs_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_hsel = 1'b0;
    logic [31:0] i_haddr = 32'h0000_0000;
    logic [1:0] i_htrans = 2'b00;
    logic i_hwrite = 1'b0;
    logic [31:0] i_hwdata = 32'h0000_0000;
    pfs_xacc_t i_xacc = '{16'h0000, 1'b1, 1'b1};
    logic [3:0] pull_low = 4'h0;
    logic [3:0] pin_lvl, o_pin, o_pin_oe;
    logic [31:0] o_hrdata, rd;
    logic o_hreadyout, o_hresp, o_external_irq_b_n, o_external_irq_c_n;
    int err_total = 0;
    int tests_run = 0;
    always #20 i_mclk = ~i_mclk;
    pfs_port u_pfs_port (.i_mclk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'b010), .i_hwdata,
        .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_xacc, .i_pin(pin_lvl), .o_pin, .o_pin_oe,
        .o_external_irq_b_n, .o_external_irq_c_n);
    pfs_periph u_pfs_periph (.i_drive(o_pin), .i_drive_oe(o_pin_oe), .i_pull_low(pull_low), .o_level(pin_lvl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_hsel <= 1'b1;
        i_haddr <= {24'h00_0000, a};
        i_htrans <= 2'b10;
        i_hwrite <= wr;
        do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'b00;
        i_hwdata <= d;
        do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk
    // Drives one core access, then checks all four pins two cycles after it lands.
    task automatic xs(input logic [15:0] a, input logic rd_n, input logic wr_n, input logic [3:0] exp);
        @(posedge i_mclk);
        i_xacc <= '{a, rd_n, wr_n};
        repeat (2) @(posedge i_mclk);
        chk({28'h000_0000, o_pin}, {28'h000_0000, exp});
        i_xacc.rd_n <= 1'b1;
        i_xacc.wr_n <= 1'b1;
    endtask : xs
    task automatic conclude();
        $display("checks=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (5000) @(posedge i_mclk);
        err_total++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        rchk(PFS_OFS_DATA, 32'h0000_000f);
        rchk(PFS_OFS_MODE_A, 32'h0000_0000);
        rchk(8'h30, 32'h0000_0000);
        bus(1'b1, PFS_OFS_DATA, 32'h0000_0005);
        repeat (4) @(posedge i_mclk);
        chk({28'h000_0000, o_pin_oe}, 32'h0000_000a);
        rchk(PFS_OFS_PIN_STATE, 32'h0000_0005);
        rchk(PFS_OFS_DATA, 32'h0000_0005);
        bus(1'b1, PFS_OFS_DATA, 32'h0000_000f);
        bus(1'b1, PFS_OFS_IRQ_EN, 32'h0000_0003);
        pull_low <= 4'b1000;
        repeat (6) @(posedge i_mclk);
        chk({30'h0000_0000, o_external_irq_b_n, o_external_irq_c_n}, 32'h0000_0001);
        pull_low <= 4'b0100;
        repeat (6) @(posedge i_mclk);
        chk({30'h0000_0000, o_external_irq_b_n, o_external_irq_c_n}, 32'h0000_0002);
        bus(1'b1, PFS_OFS_IRQ_EN, 32'h0000_0000);
        repeat (6) @(posedge i_mclk);
        chk({30'h0000_0000, o_external_irq_b_n, o_external_irq_c_n}, 32'h0000_0003);
        pull_low <= 4'b0000;
        bus(1'b1, PFS_OFS_CMP_BASE, 32'h0000_1234);
        bus(1'b1, PFS_OFS_CMP_BASE + PFS_OFS_CMP_STEP, 32'h0000_abcd);
        rchk(PFS_OFS_CMP_BASE, 32'h0000_1234);
        for (int m = 1; m < 4; m++) begin
            bus(1'b1, PFS_OFS_MODE_A, {24'h00_0000, 4'h8, m[1:0], 2'b10});
            xs(16'h1234, 1'b0, 1'b1, {3'b001, ~m[0]});
            xs(16'h1237, 1'b1, 1'b0, {3'b001, ~m[1]});
            xs(16'h1238, 1'b0, 1'b1, 4'b0011);
        end
        chk({28'h000_0000, o_pin_oe}, 32'h0000_0003);
        xs(16'habcd, 1'b1, 1'b0, 4'b0001);
        xs(16'habcc, 1'b1, 1'b0, 4'b0011);
        xs(16'habcd, 1'b0, 1'b1, 4'b0011);
        bus(1'b1, PFS_OFS_INV, 32'h0000_0001);
        xs(16'h1235, 1'b0, 1'b1, 4'b0011);
        xs(16'h2000, 1'b0, 1'b1, 4'b0010);
        bus(1'b1, PFS_OFS_CMP_BASE + 8'h08, 32'h0000_5555);
        bus(1'b1, PFS_OFS_CMP_BASE + 8'h0c, 32'h0000_6666);
        bus(1'b1, PFS_OFS_MODE_B, 32'h0000_00c4);
        rchk(PFS_OFS_MODE_B, 32'h0000_00c4);
        xs(16'h5555, 1'b0, 1'b1, 4'b1010);
        xs(16'h6666, 1'b1, 1'b0, 4'b0110);
        conclude();
    end
endmodule : tb_top
